// >>> verilog/dmc_defs.svh
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH

// ************************************************************
// Timing
// ************************************************************
`define DMC_CLK_MHZ 100
`define DMC_RESET_US 270
`define DMC_CLEAR_US 35
`define DMC_CLEAR_CYC (`DMC_CLEAR_US * `DMC_CLK_MHZ)
`define DMC_POR_US 10
`define DMC_CALC_CYC 5'h10

// ************************************************************
// Channels and command word
// ************************************************************
`define DMC_NCH 40
`define DMC_W_RW 22
`define DMC_W_ADDR 21:16
`define DMC_W_REG 15:14
`define DMC_W_DATA 13:0
`define DMC_W_MON 13:8
`define DMC_REG_SFR 2'h0
`define DMC_REG_GAIN 2'h1
`define DMC_REG_OFFS 2'h2
`define DMC_REG_DATA 2'h3
`define DMC_SFR_CLRCODE 6'h01
`define DMC_SFR_SOFTCLR 6'h02
`define DMC_SFR_PD 6'h08
`define DMC_SFR_PU 6'h09
`define DMC_SFR_MON 6'h0a
`define DMC_SFR_CTRL 6'h0c

// ************************************************************
// Reset values and fields
// ************************************************************
`define DMC_CTRL_RST 14'h2000
`define DMC_CTRL_MONEN 9
`define DMC_CTRL_PDST 13
`define DMC_GAIN_RST 14'h3fff
`define DMC_OFFS_RST 14'h2000
`define DMC_MON_HIZ 6'h3f
`define DMC_MON_LAST 6'h27

// ************************************************************
// Synchronised inputs
// ************************************************************
`define DMC_NPIN 7
`define DMC_P_RST 0
`define DMC_P_CLR 1
`define DMC_P_LOAD 2
`define DMC_P_SEL 3
`define DMC_P_PD 4
`define DMC_P_AWAKE 5
`define DMC_P_TGL 6
`define DMC_PIN_RST 7'h07

`endif

// >>> verilog/dmc_pkg.sv
package dmc_pkg;

  typedef enum logic [1:0] {
    ST_POR   = 2'b00,
    ST_RESET = 2'b01,
    ST_CLEAR = 2'b10,
    ST_RUN   = 2'b11
  } dmc_mode_t;

  typedef logic [13:0] dmc_code_t;
  typedef logic [23:0] dmc_word_t;
  typedef logic [5:0]  dmc_chan_t;
  typedef logic [39:0] dmc_mask_t;

endpackage : dmc_pkg

// >>> verilog/dmc_control.sv
// Contract
// - Monitor command carries channel in bits 13:8
// - Monitor enabled: top channel pin becomes monitor
// - Codes 0 to 39 route that channel
// - Code 63 floats the monitor output
// - Reset pin fall restores power-on register values
// - Busy low for 270 us reset sequence
// - During reset busy: interfaces off, loads dropped
// - After reset only next falling edge counts
// - Clear loads clear code everywhere, 35 us
// - Channel write starts recalculation, busy held low
// - Writes accepted during calculation, outputs frozen
// - Load during calculation applied when busy ends
// - Load held low updates whenever busy ends
// - Load copies only freshly corrected channels
// - Power-on: busy low, interfaces off, loads ignored
// - Power-on: defaults, outputs floating, writes refused
// - Power-down keeps registers, floats or loads outputs
// - Select pin picks four-wire or two-wire port
// - Port wakes only on frame falling edge
// - Monitor enable bit gates routing, default off
// - Power-down state bit: 1 float, 0 load
// - Select low two-wire, high four-wire
`include "dmc_defs.svh"

module dmc_control #(
  parameter int unsigned RESET_CYC = `DMC_RESET_US * `DMC_CLK_MHZ,
  parameter int unsigned POR_CYC   = `DMC_POR_US * `DMC_CLK_MHZ
) (
  input  wire logic                               clk_sys,
  input  wire logic                               rstn,
  input  wire logic                               linkClk,
  input  wire logic                               linkFrameN,
  input  wire logic                               linkWordValid,
  input  wire logic                               linkWordI2c,
  input  wire dmc_pkg::dmc_word_t                 linkWord,
  input  wire logic                               resetPinN,
  input  wire logic                               clearPinN,
  input  wire logic                               loadStrobeN,
  input  wire logic                               ifaceSel,
  input  wire logic                               powerDownPin,
  output logic                                    busyN_r,
  output dmc_pkg::dmc_code_t [`DMC_NCH-1:0]       chanCode_r,
  output logic                                    chanDrive_r,
  output logic                                    chanLoadGnd_r,
  output dmc_pkg::dmc_code_t                      topChanCode_r,
  output logic                                    topChanDrive_r,
  output logic                                    monitorActive_r,
  output logic                                    fourWireActive_r,
  output logic                                    twoWireActive_r,
  output logic                                    ifaceAwake_r
);
  import dmc_pkg::*;

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic dmc_mask_t dmc_onehot(input dmc_chan_t ch);
    dmc_mask_t v;
    v = '0;
    for (int i = 0; i < `DMC_NCH; i++) begin
      v[i] = (ch == 6'(i));
    end
    return v;
  endfunction : dmc_onehot

  function automatic dmc_chan_t dmc_first(input dmc_mask_t v);
    dmc_chan_t ch;
    ch = 6'h00;
    for (int i = `DMC_NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        ch = 6'(i);
      end
    end
    return ch;
  endfunction : dmc_first

  // Gain of all ones is unity; offset midscale adds nothing.
  function automatic dmc_code_t dmc_calib(input dmc_code_t x,
                                          input dmc_code_t m,
                                          input dmc_code_t c);
    logic        [28:0] prod;
    logic signed [16:0] sum;
    prod = {15'h0000, x} * {14'h0000, 15'({1'b0, m} + 15'h0001)};
    sum  = $signed({3'h0, prod[27:14]}) + $signed({3'h0, c}) - 17'sh02000;
    if (sum < 17'sh00000) begin
      return 14'h0000;
    end else if (sum > 17'sh03fff) begin
      return 14'h3fff;
    end
    return sum[13:0];
  endfunction : dmc_calib

  // ************************************************************
  // Link domain
  // ************************************************************
  logic [2:0]  lRst_r;
  logic        linkUp;
  logic        framePrev_r;
  logic        linkAwake_r;
  logic        linkTgl_r;
  dmc_word_t   linkHold_r;
  logic        linkHoldI2c_r;
  logic        frameFall;

  always_ff @(posedge linkClk) begin
    lRst_r <= {lRst_r[1:0], rstn};
  end

  assign linkUp    = lRst_r[2] & lRst_r[1];
  assign frameFall = framePrev_r & ~linkFrameN;

  // The held word is read by the system side only after the toggle
  // has crossed, so the host must space words; no FIFO is kept.
  always_ff @(posedge linkClk) begin
    if (!linkUp) begin
      framePrev_r   <= 1'b1;
      linkAwake_r   <= 1'b0;
      linkTgl_r     <= 1'b0;
      linkHold_r    <= '0;
      linkHoldI2c_r <= 1'b0;
    end else begin
      framePrev_r <= linkFrameN;
      if (frameFall) begin
        linkAwake_r <= 1'b1;
      end else if (linkWordValid) begin
        linkAwake_r <= 1'b0;
      end
      if (linkWordValid && (linkAwake_r || frameFall)) begin
        linkHold_r    <= linkWord;
        linkHoldI2c_r <= linkWordI2c;
        linkTgl_r     <= ~linkTgl_r;
      end
    end
  end

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [`DMC_NPIN-1:0] pinRaw;
  logic [`DMC_NPIN-1:0] pinS1_r;
  logic [`DMC_NPIN-1:0] pinS2_r;
  logic [`DMC_NPIN-1:0] pinS3_r;
  logic [`DMC_NPIN-1:0] pinLvl_r;
  logic [`DMC_NPIN-1:0] pinPrev_r;
  logic [`DMC_NPIN-1:0] pinFall;

  assign pinRaw = {linkTgl_r, linkAwake_r, powerDownPin, ifaceSel,
                   loadStrobeN, clearPinN, resetPinN};

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pinS1_r   <= `DMC_PIN_RST;
      pinS2_r   <= `DMC_PIN_RST;
      pinS3_r   <= `DMC_PIN_RST;
      pinLvl_r  <= `DMC_PIN_RST;
      pinPrev_r <= `DMC_PIN_RST;
    end else begin
      pinS1_r   <= pinRaw;
      pinS2_r   <= pinS1_r;
      pinS3_r   <= pinS2_r;
      pinLvl_r  <= (pinS2_r & pinS3_r) | (pinLvl_r & (pinS2_r ^ pinS3_r));
      pinPrev_r <= pinLvl_r;
    end
  end

  assign pinFall = pinPrev_r & ~pinLvl_r;

  // ************************************************************
  // Command decode
  // ************************************************************
  dmc_mode_t mode_r;
  logic      [15:0] seqCnt_r;
  logic      porDone_r;
  dmc_code_t ctrl_r;
  dmc_chan_t monSel_r;
  dmc_code_t clrCode_r;
  logic      softPd_r;
  logic      pdNow;
  logic      ifaceOn;
  logic      portOk;
  logic      cmdEvt;
  logic      wrEn;
  logic      sfrWr;
  logic      chanWr;
  logic      resetFall;
  logic      clrStart;
  logic      [1:0] regSel;
  dmc_chan_t addr;
  dmc_code_t data;

  assign regSel = linkHold_r[`DMC_W_REG];
  assign addr   = linkHold_r[`DMC_W_ADDR];
  assign data   = linkHold_r[`DMC_W_DATA];
  assign pdNow  = pinLvl_r[`DMC_P_PD] | softPd_r;

  assign ifaceOn = (mode_r == ST_CLEAR) || (mode_r == ST_RUN);
  assign portOk  = linkHoldI2c_r == ~pinLvl_r[`DMC_P_SEL];
  assign cmdEvt  = (pinLvl_r[`DMC_P_TGL] ^ pinPrev_r[`DMC_P_TGL]) && portOk && ifaceOn
                   && !linkHold_r[`DMC_W_RW];
  assign wrEn    = cmdEvt && (!pdNow || (regSel == `DMC_REG_SFR && addr == `DMC_SFR_PU));
  assign sfrWr   = wrEn && (regSel == `DMC_REG_SFR);
  assign chanWr  = wrEn && (regSel != `DMC_REG_SFR) && (addr <= `DMC_MON_LAST);

  assign resetFall = pinFall[`DMC_P_RST];
  assign clrStart  = (mode_r == ST_RUN) && !resetFall
                     && (pinFall[`DMC_P_CLR] || (sfrWr && addr == `DMC_SFR_SOFTCLR));

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_r   <= ST_POR;
      seqCnt_r <= 16'(POR_CYC - 1);
    end else begin
      unique case (mode_r)
        ST_POR, ST_RESET: begin
          if (seqCnt_r == 16'h0000) begin
            mode_r <= ST_RUN;
          end else begin
            seqCnt_r <= seqCnt_r - 16'h0001;
          end
        end
        ST_CLEAR, ST_RUN: begin
          if (resetFall) begin
            mode_r   <= ST_RESET;
            seqCnt_r <= 16'(RESET_CYC - 1);
          end else if (mode_r == ST_CLEAR) begin
            if (seqCnt_r == 16'h0000) begin
              mode_r <= ST_RUN;
            end else begin
              seqCnt_r <= seqCnt_r - 16'h0001;
            end
          end else if (clrStart) begin
            mode_r   <= ST_CLEAR;
            seqCnt_r <= 16'(`DMC_CLEAR_CYC - 1);
          end
        end
      endcase
    end
  end

  // Power-on floating ends with the first power-on sequence; a reset pin sequence does not bring it back.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      porDone_r <= 1'b0;
    end else if (mode_r == ST_POR && seqCnt_r == 16'h0000) begin
      porDone_r <= 1'b1;
    end
  end

  // ************************************************************
  // Special function state
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn || mode_r == ST_RESET) begin
      ctrl_r    <= `DMC_CTRL_RST;
      monSel_r  <= `DMC_MON_HIZ;
      clrCode_r <= 14'h0000;
      softPd_r  <= 1'b0;
    end else if (sfrWr) begin
      case (addr)
        `DMC_SFR_CTRL:    ctrl_r    <= data;
        `DMC_SFR_MON:     monSel_r  <= linkHold_r[`DMC_W_MON];
        `DMC_SFR_CLRCODE: clrCode_r <= data;
        `DMC_SFR_PD:      softPd_r  <= 1'b1;
        `DMC_SFR_PU:      softPd_r  <= 1'b0;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Channel registers and calculation
  // ************************************************************
  dmc_code_t inData_r [`DMC_NCH];
  dmc_code_t gain_r [`DMC_NCH];
  dmc_code_t offs_r [`DMC_NCH];
  dmc_code_t corr_r [`DMC_NCH];
  dmc_mask_t pend_r;
  dmc_mask_t dirty_r;
  dmc_mask_t dirty_nxt;
  dmc_mask_t startMask;
  dmc_mask_t wrMask;
  dmc_chan_t nextCh;
  dmc_chan_t calcCh_r;
  logic      [4:0] calcCnt_r;
  logic      calcRun_r;
  logic      calcDone;
  logic      busyNow;
  logic      loadPend_r;
  logic      update;

  assign nextCh    = dmc_first(pend_r);
  assign startMask = (!calcRun_r && |pend_r) ? dmc_onehot(nextCh) : '0;
  assign wrMask    = chanWr ? dmc_onehot(addr) : '0;
  assign calcDone  = calcRun_r && (calcCnt_r == 5'h00);

  always_ff @(posedge clk_sys) begin
    if (!rstn || mode_r == ST_RESET) begin
      for (int i = 0; i < `DMC_NCH; i++) begin
        inData_r[i] <= 14'h0000;
        gain_r[i]   <= `DMC_GAIN_RST;
        offs_r[i]   <= `DMC_OFFS_RST;
        corr_r[i]   <= 14'h0000;
      end
    end else begin
      if (chanWr) begin
        case (regSel)
          `DMC_REG_DATA: inData_r[addr] <= data;
          `DMC_REG_GAIN: gain_r[addr]   <= data;
          `DMC_REG_OFFS: offs_r[addr]   <= data;
          default: ;
        endcase
      end
      if (calcDone) begin
        corr_r[calcCh_r] <= dmc_calib(inData_r[calcCh_r], gain_r[calcCh_r],
                                      offs_r[calcCh_r]);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn || mode_r == ST_RESET) begin
      pend_r    <= '0;
      calcRun_r <= 1'b0;
      calcCh_r  <= 6'h00;
      calcCnt_r <= 5'h00;
    end else begin
      if (!calcRun_r && |pend_r) begin
        calcRun_r <= 1'b1;
        calcCh_r  <= nextCh;
        calcCnt_r <= `DMC_CALC_CYC - 5'h01;
      end else if (calcDone) begin
        calcRun_r <= 1'b0;
      end else if (calcRun_r) begin
        calcCnt_r <= calcCnt_r - 5'h01;
      end
      pend_r <= (pend_r & ~startMask) | wrMask;
    end
  end

  assign busyNow = (mode_r != ST_RUN) || calcRun_r || (|pend_r);

  // ************************************************************
  // Load strobe and output update
  // ************************************************************
  // deferred or held load
  assign update = !busyNow && !clrStart && (loadPend_r || !pinLvl_r[`DMC_P_LOAD]);

  always_ff @(posedge clk_sys) begin
    if (!rstn || mode_r == ST_POR || mode_r == ST_RESET) begin
      loadPend_r <= 1'b0;
    end else if (pinFall[`DMC_P_LOAD]) begin
      loadPend_r <= 1'b1;
    end else if (update) begin
      loadPend_r <= 1'b0;
    end
  end

  always_comb begin
    dirty_nxt = dirty_r;
    if (update) begin
      dirty_nxt = '0;
    end
    if (calcDone) begin
      dirty_nxt = dirty_nxt | dmc_onehot(calcCh_r);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn || mode_r == ST_RESET) begin
      dirty_r <= '0;
    end else begin
      dirty_r <= dirty_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn || mode_r == ST_RESET) begin
      chanCode_r <= '0;
    end else if (clrStart) begin
      for (int i = 0; i < `DMC_NCH; i++) begin
        chanCode_r[i] <= clrCode_r;
      end
    end else if (update) begin
      for (int i = 0; i < `DMC_NCH; i++) begin
        if (dirty_r[i]) begin
          chanCode_r[i] <= corr_r[i];
        end
      end
    end
  end

  // ************************************************************
  // Pin outputs
  // ************************************************************
  logic monEn;
  logic drvNow;

  assign monEn  = ctrl_r[`DMC_CTRL_MONEN];
  assign drvNow = porDone_r && !pdNow;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      busyN_r          <= 1'b0;
      chanDrive_r      <= 1'b0;
      chanLoadGnd_r    <= 1'b0;
      topChanCode_r    <= 14'h0000;
      topChanDrive_r   <= 1'b0;
      monitorActive_r  <= 1'b0;
      fourWireActive_r <= 1'b0;
      twoWireActive_r  <= 1'b0;
      ifaceAwake_r     <= 1'b0;
    end else begin
      busyN_r       <= !busyNow;
      chanDrive_r   <= drvNow;
      chanLoadGnd_r <= porDone_r && pdNow && !ctrl_r[`DMC_CTRL_PDST];
      if (!monEn) begin
        topChanCode_r  <= chanCode_r[`DMC_NCH-1];
        topChanDrive_r <= drvNow;
      end else begin
        topChanCode_r  <= (monSel_r <= `DMC_MON_LAST) ? chanCode_r[monSel_r] : 14'h0000;
        topChanDrive_r <= drvNow && (monSel_r != `DMC_MON_HIZ);
      end
      monitorActive_r  <= monEn;
      fourWireActive_r <= pinLvl_r[`DMC_P_SEL];
      twoWireActive_r  <= !pinLvl_r[`DMC_P_SEL];
      ifaceAwake_r     <= pinLvl_r[`DMC_P_AWAKE];
    end
  end

endmodule : dmc_control

// >>> test/dmc_control_sva.sv
`include "dmc_defs.svh"

module dmc_chk (
  input wire logic                              clk_sys,
  input wire logic                              rstn,
  input wire logic                              resetPinN,
  input wire logic                              clearPinN,
  input wire logic                              ifaceSel,
  input wire logic                              powerDownPin,
  input wire logic                              busyN_r,
  input wire dmc_pkg::dmc_code_t [`DMC_NCH-1:0] chanCode_r,
  input wire logic                              chanDrive_r,
  input wire dmc_pkg::dmc_code_t                topChanCode_r,
  input wire logic                              monitorActive_r,
  input wire logic                              fourWireActive_r,
  input wire logic                              twoWireActive_r
);
  timeunit 1ns;
  timeprecision 1ps;
  import dmc_pkg::*;

  // ****************************************
  // Sequences and assertions
  // ****************************************
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence heldOff;
    !busyN_r && !chanDrive_r;
  endsequence

  sequence busyLow8;
    !busyN_r [*8];
  endsequence

  por_hold_a: assert property ($rose(rstn) |-> heldOff [*8])
    else $error("busy or drive too early after power-on");
  rst_busy_a: assert property ($fell(resetPinN) |-> ##8 busyLow8)
    else $error("busy not held low by reset pin");
  rst_clear_a: assert property ($fell(resetPinN) |-> ##10 chanCode_r == '0)
    else $error("codes not cleared by reset pin");
  rst_level_a: assert property ($rose(busyN_r) && !resetPinN |-> busyN_r [*8])
    else $error("low reset level restarted reset");
  clr_busy_a: assert property ($fell(clearPinN) && busyN_r |-> ##[2:10] !busyN_r)
    else $error("clear did not raise busy");
  calc_hold_a: assert property (!busyN_r && !$past(busyN_r) && clearPinN && $past(clearPinN, 8)
      && resetPinN && $past(resetPinN, 8) |-> $stable(chanCode_r))
    else $error("codes changed while busy");
  mon_off_a: assert property (!monitorActive_r && !$past(monitorActive_r)
      |-> topChanCode_r == $past(chanCode_r[39]))
    else $error("top channel not following its own code");
  sel_port_a: assert property ($changed(ifaceSel) |-> ##8
      (fourWireActive_r == ifaceSel && twoWireActive_r == !ifaceSel))
    else $error("port select not followed");
  pd_float_a: assert property ($rose(powerDownPin) |-> ##8
      (!chanDrive_r && chanCode_r == $past(chanCode_r, 8)))
    else $error("power-down drive or codes wrong");
endmodule : dmc_chk

// >>> test/dmc_host_model.sv
module dmc_host_model (
  output logic               linkClk,
  output logic               linkFrameN,
  output logic               linkWordValid,
  output logic               linkWordI2c,
  output dmc_pkg::dmc_word_t linkWord
);
  timeunit 1ns;
  timeprecision 1ps;
  import dmc_pkg::*;

  initial begin
    linkClk = 1'b0;
    linkFrameN = 1'b1;
    linkWordValid = 1'b0;
    linkWordI2c = 1'b0;
    linkWord = 24'h000000;
  end

  // The link clock runs only while a caller asks for edges.
  task automatic tick(input int n);
    repeat (n) begin
      #16 linkClk = 1'b1;
      #16 linkClk = 1'b0;
    end
  endtask : tick

  task automatic send(input dmc_word_t w, input logic i2c);
    linkFrameN = 1'b0;
    tick(1);
    linkWordValid = 1'b1;
    linkWord = w;
    linkWordI2c = i2c;
    tick(1);
    linkWordValid = 1'b0;
    linkWord = ~w;
    linkFrameN = 1'b1;
    tick(4);
  endtask : send

  task automatic wake();
    linkFrameN = 1'b0;
    tick(2);
    linkFrameN = 1'b1;
    tick(2);
  endtask : wake
endmodule : dmc_host_model

// >>> test/tb_top.sv
`include "dmc_defs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dmc_pkg::*;

  logic clk_sys = 1'b0;
  logic rstn, resetPinN, clearPinN, loadStrobeN, ifaceSel, powerDownPin;
  logic linkClk, linkFrameN, linkWordValid, linkWordI2c;
  logic busyN_r, chanDrive_r, chanLoadGnd_r, topChanDrive_r, monitorActive_r;
  logic fourWireActive_r, twoWireActive_r, ifaceAwake_r;
  dmc_word_t linkWord;
  dmc_code_t [`DMC_NCH-1:0] chanCode_r;
  dmc_code_t topChanCode_r;
  dmc_code_t expCode [`DMC_NCH];
  int bad_count = 0;
  int n_checks = 0;

  always #5 clk_sys = ~clk_sys;

  dmc_control #(.RESET_CYC(50), .POR_CYC(40)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .linkClk(linkClk), .linkFrameN(linkFrameN),
    .linkWordValid(linkWordValid), .linkWordI2c(linkWordI2c), .linkWord(linkWord),
    .resetPinN(resetPinN), .clearPinN(clearPinN), .loadStrobeN(loadStrobeN), .ifaceSel(ifaceSel),
    .powerDownPin(powerDownPin), .busyN_r(busyN_r), .chanCode_r(chanCode_r), .chanDrive_r(chanDrive_r),
    .chanLoadGnd_r(chanLoadGnd_r), .topChanCode_r(topChanCode_r), .topChanDrive_r(topChanDrive_r),
    .monitorActive_r(monitorActive_r), .fourWireActive_r(fourWireActive_r),
    .twoWireActive_r(twoWireActive_r), .ifaceAwake_r(ifaceAwake_r)
  );

  dmc_host_model host (.linkClk(linkClk), .linkFrameN(linkFrameN), .linkWordValid(linkWordValid),
    .linkWordI2c(linkWordI2c), .linkWord(linkWord));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input dmc_code_t seen, input dmc_code_t want);
    n_checks++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  function automatic dmc_word_t mk(input dmc_chan_t a, input logic [1:0] r, input dmc_code_t d);
    return {2'b00, a, r, d};
  endfunction : mk

  task automatic checkAll();
    for (int i = 0; i < `DMC_NCH; i++) begin
      chk(chanCode_r[i], expCode[i]);
    end
  endtask : checkAll

  task automatic waitBusy(input logic lvl);
    int n;
    n = 0;
    while (busyN_r !== lvl && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(14'(n < 5000), 14'h0001);
  endtask : waitBusy

  task automatic busySpan(output int n);
    waitBusy(1'b0);
    n = 0;
    while (busyN_r !== 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : busySpan

  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b0;
    repeat (8) @(negedge clk_sys);
    s = 1'b1;
    repeat (6) @(negedge clk_sys);
  endtask : pulse

  task automatic load();
    pulse(loadStrobeN);
    waitBusy(1'b1);
    repeat (2) @(negedge clk_sys);
  endtask : load

  // A write leaves the outputs alone until the calculation ends.
  task automatic wr(input dmc_chan_t a, input logic [1:0] r, input dmc_code_t v);
    host.send(mk(a, r, v), ~ifaceSel);
    chk(14'(busyN_r), 14'h0000);
    chk(chanCode_r[a], expCode[a]);
    waitBusy(1'b1);
    repeat (2) @(negedge clk_sys);
  endtask : wr

  task automatic sfr(input dmc_chan_t a, input dmc_code_t v);
    host.send(mk(a, `DMC_REG_SFR, v), ~ifaceSel);
    repeat (6) @(negedge clk_sys);
  endtask : sfr

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testPor();
    repeat (3) @(negedge clk_sys);
    chk(14'({busyN_r, chanDrive_r}), 14'h0000);
    host.send(mk(6'h01, `DMC_REG_DATA, 14'h0abc), 1'b0);
    waitBusy(1'b1);
    repeat (2) @(negedge clk_sys);
    chk(14'({chanDrive_r, monitorActive_r, topChanDrive_r}), 14'h0005);
    load();
    checkAll();
  endtask : testPor

  task automatic testLoad();
    host.send(mk(6'h05, `DMC_REG_DATA, 14'h0155), ~ifaceSel);
    wr(6'h06, `DMC_REG_DATA, 14'h2aaa);
    load();
    expCode[5] = 14'h0155;
    expCode[6] = 14'h2aaa;
    checkAll();
  endtask : testLoad

  task automatic testBusyLoad();
    host.send(mk(6'h07, `DMC_REG_DATA, 14'h0777), ~ifaceSel);
    @(negedge clk_sys);
    loadStrobeN = 1'b0;
    repeat (3) @(negedge clk_sys);
    loadStrobeN = 1'b1;
    chk(chanCode_r[7], expCode[7]);
    waitBusy(1'b1);
    repeat (2) @(negedge clk_sys);
    chk(chanCode_r[7], 14'h0777);
    expCode[7] = 14'h0777;
  endtask : testBusyLoad

  task automatic testHeldLoad();
    @(negedge clk_sys);
    loadStrobeN = 1'b0;
    wr(6'h08, `DMC_REG_DATA, 14'h3ffe);
    expCode[8] = 14'h3ffe;
    checkAll();
    loadStrobeN = 1'b1;
  endtask : testHeldLoad

  task automatic testClear();
    int n;
    sfr(`DMC_SFR_CLRCODE, 14'h1234);
    fork
      pulse(clearPinN);
      busySpan(n);
    join
    chk(14'(n >= 3495 && n <= 3505), 14'h0001);
    foreach (expCode[i]) expCode[i] = 14'h1234;
    checkAll();
    load();
    checkAll();
  endtask : testClear

  task automatic testMonitor();
    dmc_chan_t sels [4] = '{6'h00, 6'h05, 6'h27, 6'h3f};
    wr(6'h05, `DMC_REG_DATA, 14'h0a5a);
    wr(6'h27, `DMC_REG_DATA, 14'h1c3c);
    load();
    expCode[5] = 14'h0a5a;
    expCode[39] = 14'h1c3c;
    chk(topChanCode_r, expCode[39]);
    sfr(`DMC_SFR_CTRL, 14'h2200);
    foreach (sels[k]) begin
      sfr(`DMC_SFR_MON, {sels[k], 8'hff});
      chk(14'({monitorActive_r, topChanDrive_r}), 14'({1'b1, sels[k] != 6'h3f}));
      if (sels[k] != 6'h3f) chk(topChanCode_r, expCode[sels[k]]);
    end
  endtask : testMonitor

  task automatic testPowerDown();
    for (int k = 0; k < 2; k++) begin
      sfr(`DMC_SFR_CTRL, k ? 14'h2000 : 14'h0000);
      powerDownPin = 1'b1;
      repeat (10) @(negedge clk_sys);
      host.send(mk(6'h05, `DMC_REG_DATA, 14'h0001), ~ifaceSel);
      chk(14'({chanDrive_r, chanLoadGnd_r}), 14'(k == 0));
      @(negedge clk_sys);
      powerDownPin = 1'b0;
      repeat (10) @(negedge clk_sys);
      chk(14'(chanDrive_r), 14'h0001);
    end
    load();
    checkAll();
  endtask : testPowerDown

  task automatic testIface();
    @(negedge clk_sys);
    ifaceSel = 1'b0;
    repeat (10) @(negedge clk_sys);
    chk(14'({fourWireActive_r, twoWireActive_r}), 14'h0001);
    host.wake();
    chk(14'(ifaceAwake_r), 14'h0001);
    wr(6'h0a, `DMC_REG_DATA, 14'h0a0a);
    chk(14'(ifaceAwake_r), 14'h0000);
    host.send(mk(6'h0b, `DMC_REG_DATA, 14'h0b0b), 1'b0);
    load();
    expCode[10] = 14'h0a0a;
    checkAll();
    ifaceSel = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk(14'({fourWireActive_r, twoWireActive_r}), 14'h0002);
  endtask : testIface

  task automatic testResetPin();
    int n;
    sfr(`DMC_SFR_CTRL, 14'h2200);
    wr(6'h0e, `DMC_REG_OFFS, 14'h2100);
    wr(6'h0c, `DMC_REG_DATA, 14'h0c0c);
    resetPinN = 1'b0;
    fork
      busySpan(n);
      begin
        repeat (8) @(negedge clk_sys);
        host.send(mk(6'h0d, `DMC_REG_DATA, 14'h0d0d), ~ifaceSel);
        pulse(loadStrobeN);
      end
    join
    chk(14'(n >= 48 && n <= 54), 14'h0001);
    repeat (20) @(negedge clk_sys);
    chk(14'({busyN_r, monitorActive_r}), 14'h0002);
    foreach (expCode[i]) expCode[i] = 14'h0000;
    load();
    checkAll();
    resetPinN = 1'b1;
    wr(6'h0e, `DMC_REG_DATA, 14'h0300);
    load();
    expCode[14] = 14'h0300;
    checkAll();
  endtask : testResetPin

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  initial begin
    #200_000;
    bad_count++;
    $display("[ERR] %0t run did not finish", $time);
    results();
  end

  // The link side leaves reset only on link edges, so a few run at start-up.
  initial begin
    rstn = 1'b0;
    resetPinN = 1'b1;
    clearPinN = 1'b1;
    loadStrobeN = 1'b1;
    ifaceSel = 1'b1;
    powerDownPin = 1'b0;
    foreach (expCode[i]) expCode[i] = 14'h0000;
    fork
      host.tick(4);
      repeat (8) @(negedge clk_sys);
    join
    @(negedge clk_sys);
    rstn = 1'b1;
    host.tick(4);
    testPor();
    testLoad();
    testBusyLoad();
    testHeldLoad();
    testClear();
    testMonitor();
    testPowerDown();
    testIface();
    testResetPin();
    results();
  end
endmodule : tb_top

bind dmc_control dmc_chk chk (.clk_sys(clk_sys), .rstn(rstn), .resetPinN(resetPinN), .clearPinN(clearPinN),
  .ifaceSel(ifaceSel), .powerDownPin(powerDownPin), .busyN_r(busyN_r), .chanCode_r(chanCode_r),
  .chanDrive_r(chanDrive_r), .topChanCode_r(topChanCode_r), .monitorActive_r(monitorActive_r),
  .fourWireActive_r(fourWireActive_r), .twoWireActive_r(twoWireActive_r));
